// ===== pci_cfg_pkg.sv
package pci_cfg_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_ID        = 8'h00;
	localparam logic [7:0] OFS_CMD_STAT  = 8'h04;
	localparam logic [7:0] OFS_CLASS     = 8'h08;
	localparam logic [7:0] OFS_LATENCY   = 8'h0c;
	localparam logic [7:0] OFS_IO_BASE   = 8'h10;
	localparam logic [7:0] OFS_MEM_BASE  = 8'h14;
	localparam logic [7:0] OFS_RSVD_LOW  = 8'h18;
	localparam logic [7:0] OFS_SUBSYS    = 8'h2c;
	localparam logic [7:0] OFS_ROM_BASE  = 8'h30;
	localparam logic [7:0] OFS_CAP_PTR   = 8'h34;
	localparam logic [7:0] OFS_INTR      = 8'h3c;
	localparam logic [7:0] OFS_SCRATCH   = 8'h40;
	localparam logic [7:0] OFS_SIGNATURE = 8'h80;
	localparam logic [7:0] OFS_PM_CAP    = 8'hc0;
	localparam logic [7:0] OFS_PM_CTRL   = 8'hc4;

	// ------------------------------------------------------------
	// Configuration commands
	// ------------------------------------------------------------
	localparam logic [3:0] CMD_CFG_READ  = 4'ha;
	localparam logic [3:0] CMD_CFG_WRITE = 4'hb;

	// ------------------------------------------------------------
	// Command and status fields
	// ------------------------------------------------------------
	localparam int         CMD_IO_BIT     = 0;
	localparam int         CMD_MEM_BIT    = 1;
	localparam int         CMD_MASTER_BIT = 2;
	localparam int         CMD_PERR_BIT   = 6;
	localparam int         CMD_SERR_BIT   = 8;
	localparam logic [8:0] CMD_RESET      = 9'h107;
	localparam logic [8:0] CMD_WR_MASK    = 9'h147;
	localparam int         ST_SPE_BIT     = 31;
	localparam int         ST_SES_BIT     = 30;
	localparam int         ST_SMA_BIT     = 29;
	localparam int         ST_STA_BIT     = 28;
	localparam int         ST_SDST_LSB    = 25;
	localparam logic [1:0] ST_SDST_VAL    = 2'h1;
	localparam int         ST_SDPR_BIT    = 24;
	localparam int         ST_SFBB_BIT    = 23;
	localparam int         ST_NC_BIT      = 20;

	// ------------------------------------------------------------
	// Window sizes and fixed fields
	// ------------------------------------------------------------
	localparam int          IO_BASE_LSB  = 7;
	localparam int          MEM_BASE_LSB = 7;
	localparam int          ROM_BASE_LSB = 14;
	localparam logic [23:0] CLASS_CODE   = 24'h020000;
	localparam logic [7:0]  REV_STEP     = 8'h00;
	localparam logic [7:0]  INTR_PIN     = 8'h01;
	localparam logic [7:0]  CAP_PTR      = 8'hc0;
	// Arbitrary value
	localparam logic [31:0] SIGNATURE    = 32'h5a5a_0001;
	localparam logic [7:0]  PM_CAP_CODE  = 8'h01;
	localparam logic [7:0]  PM_NEXT_LINK = 8'h00;
	localparam logic [15:0] PM_CAPS      = 16'h0002;
	localparam int          PMCS_PME_EN  = 8;
	localparam int          PMCS_PME_ST  = 15;

	// ------------------------------------------------------------
	// EEPROM recall words and transceiver register map
	// ------------------------------------------------------------
	localparam logic [2:0] EE_VENDOR   = 3'h0;
	localparam logic [2:0] EE_DEVICE   = 3'h1;
	localparam logic [2:0] EE_SUB_VEN  = 3'h2;
	localparam logic [2:0] EE_SUB_DEV  = 3'h3;
	localparam logic [2:0] EE_GNT_LAT  = 3'h4;
	localparam int         EE_WORDS    = 5;
	localparam logic [4:0] MII_STD_LAST  = 5'h06;
	localparam logic [4:0] MII_VND_FIRST = 5'h10;
	localparam logic [4:0] MII_VND_LAST  = 5'h13;

	typedef enum logic [1:0] {
		RC_IDLE = 2'b00,
		RC_ASK  = 2'b01,
		RC_WAIT = 2'b11,
		RC_DONE = 2'b10
	} recall_state_e;

endpackage : pci_cfg_pkg

// ===== eeprom_recall.sv
`timescale 1ns/100ps
`default_nettype none

module eeprom_recall (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	output logic             ee_req,
	output logic [2:0]       ee_word,
	input  wire logic [15:0] ee_rdata,
	input  wire logic        ee_rvalid,
	output logic [15:0]      word_q [pci_cfg_pkg::EE_WORDS],
	output logic             recall_done
);

	pci_cfg_pkg::recall_state_e state_q, state_d;
	logic [2:0]                 idx_q, idx_d;
	logic [15:0]                word_d [pci_cfg_pkg::EE_WORDS];

	// ------------------------------------------------------------
	// Recall sequence after reset release
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		idx_d   = idx_q;
		word_d  = word_q;
		case (state_q)
			pci_cfg_pkg::RC_IDLE: state_d = pci_cfg_pkg::RC_ASK; // [RULE_07]
			pci_cfg_pkg::RC_ASK:  state_d = pci_cfg_pkg::RC_WAIT;
			pci_cfg_pkg::RC_WAIT: begin
				if (ee_rvalid) begin
					word_d[idx_q] = ee_rdata; // [RULE_07]
					if (idx_q == pci_cfg_pkg::EE_GNT_LAT) begin
						state_d = pci_cfg_pkg::RC_DONE;
					end else begin
						idx_d   = idx_q + 3'h1;
						state_d = pci_cfg_pkg::RC_ASK;
					end
				end
			end
			pci_cfg_pkg::RC_DONE: state_d = pci_cfg_pkg::RC_DONE;
			default:              state_d = pci_cfg_pkg::RC_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= pci_cfg_pkg::RC_IDLE;
			idx_q   <= pci_cfg_pkg::EE_VENDOR;
			for (int i = 0; i < pci_cfg_pkg::EE_WORDS; i++) begin
				word_q[i] <= 16'h0000;
			end
		end else if (ce) begin
			state_q <= state_d;
			idx_q   <= idx_d;
			word_q  <= word_d;
		end
	end

	assign ee_req      = (state_q == pci_cfg_pkg::RC_ASK);
	assign ee_word     = idx_q;
	assign recall_done = (state_q == pci_cfg_pkg::RC_DONE);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_RECALL_STARTS: assert property (@(posedge clk) // [RULE_07]
		!rst && $past(rst) && ce |=> ee_req)
		else $error("recall did not start after reset release");

endmodule : eeprom_recall

`default_nettype wire

// ===== pci_config_register_bank.sv
// Function
// RULE_01 - Hardware reset loads every configuration register with its default.
// RULE_02 - Software reset leaves all configuration register contents unchanged.
// RULE_03 - Byte, word and double word accesses touch only enabled byte lanes.
// RULE_04 - Control/status set is reachable through I/O and memory space.
// RULE_05 - Transceiver has eleven 16-bit registers: seven standard, four vendor.
// RULE_06 - Offset 0 is read-only: loaded device number high, vendor number low.
// RULE_07 - Identity, subsystem identity, grant and latency reload from EEPROM after reset.
// RULE_08 - At 40h bits 15 to 8 are read/write scratch; others reserved.
// RULE_09 - Offset 80h returns a fixed signature; writes never change it.
// RULE_10 - Boot ROM base at 30h decodes a window sized for 128 kilobits.
// RULE_11 - Offset c0h holds capability code, next link, capabilities word upward.
// RULE_12 - Offset c4h holds control/state word low; upper half reserved.
// RULE_13 - 0ch holds line size, latency; 3ch holds line, pin, grant, latency.
// RULE_14 - Parity error flag sets on any parity error, response enabled or not.
// RULE_15 - Reserved offsets and bits read zero; writes to them are ignored.
// RULE_16 - Configuration command, dword offset and byte enables select register and lanes.
`timescale 1ns/100ps
`default_nettype none

module pci_config_register_bank (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        sw_rst,
	input  wire logic        cfg_sel,
	input  wire logic [3:0]  cfg_cmd,
	input  wire logic [5:0]  cfg_dword,
	input  wire logic [3:0]  cfg_be_n,
	input  wire logic [31:0] cfg_wdata,
	output logic             cfg_ack,
	output logic [31:0]      cfg_rdata,
	output logic             ee_req,
	output logic [2:0]       ee_word,
	input  wire logic [15:0] ee_rdata,
	input  wire logic        ee_rvalid,
	output logic             recall_done,
	input  wire logic        parity_err_det,
	input  wire logic        sys_err_sig,
	input  wire logic        master_abort_rx,
	input  wire logic        target_abort_rx,
	input  wire logic        data_parity_err,
	input  wire logic        nc_enable,
	input  wire logic        pme_event,
	input  wire logic [31:0] bus_addr,
	output logic             csr_io_hit,
	output logic             csr_mem_hit,
	output logic             rom_hit,
	input  wire logic [4:0]  mii_reg_addr,
	output logic             mii_reg_valid,
	output logic             io_space_en,
	output logic             mem_space_en,
	output logic             bus_master_en,
	output logic             parity_resp_en,
	output logic             serr_en,
	output logic [7:0]       cache_line_size,
	output logic [7:0]       latency_timer,
	output logic [7:0]       interrupt_line,
	output logic [1:0]       power_state,
	output logic             pme_en
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [8:0]   cmd_q, cmd_d;
	logic         spe_q, spe_d;
	logic         ses_q, ses_d;
	logic         sma_q, sma_d;
	logic         sta_q, sta_d;
	logic         sdpr_q, sdpr_d;
	logic [7:0]   cls_q, cls_d;
	logic [7:0]   lat_q, lat_d;
	logic [31:7]  iob_q, iob_d;
	logic [31:7]  mb_q, mb_d;
	logic [31:14] rom_q, rom_d;
	logic         rom_en_q, rom_en_d;
	logic [7:0]   iline_q, iline_d;
	logic [7:0]   drv_q, drv_d;
	logic [1:0]   ps_q, ps_d;
	logic         pme_en_q, pme_en_d;
	logic         pme_st_q, pme_st_d;
	logic         ack_q, ack_d;
	logic [31:0]  rdata_q, rdata_d;
	logic [15:0]  ee_q [pci_cfg_pkg::EE_WORDS];

	logic         take;
	logic         rd_take;
	logic         wr_take;
	logic [7:0]   byte_ofs;
	logic [31:0]  wmask;
	logic [31:0]  w1c;
	logic [31:0]  rd_img;

	eeprom_recall u_recall (
		.clk         (clk),
		.rst         (rst),
		.ce          (ce),
		.ee_req      (ee_req),
		.ee_word     (ee_word),
		.ee_rdata    (ee_rdata),
		.ee_rvalid   (ee_rvalid),
		.word_q      (ee_q),
		.recall_done (recall_done)
	);

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	assign rd_take  = ce && cfg_sel && (cfg_cmd == pci_cfg_pkg::CMD_CFG_READ);  // [RULE_16]
	assign wr_take  = ce && cfg_sel && (cfg_cmd == pci_cfg_pkg::CMD_CFG_WRITE); // [RULE_16]
	assign take     = rd_take || wr_take;
	assign byte_ofs = {cfg_dword, 2'b00};
	assign w1c      = cfg_wdata & wmask;

	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign wmask[8*i +: 8] = {8{wr_take && !cfg_be_n[i]}}; // [RULE_03]
	end

	function automatic logic [31:0] merge(input logic [31:0] old_v,
	                                      input logic [31:0] new_v,
	                                      input logic [31:0] mask);
		return (old_v & ~mask) | (new_v & mask);
	endfunction : merge

	// ------------------------------------------------------------
	// Read image; unlisted offsets and reserved bits read zero
	// ------------------------------------------------------------
	always_comb begin
		rd_img = 32'h0000_0000; // [RULE_15]
		case (byte_ofs)
			pci_cfg_pkg::OFS_ID:
				rd_img = {ee_q[pci_cfg_pkg::EE_DEVICE], ee_q[pci_cfg_pkg::EE_VENDOR]}; // [RULE_06]
			pci_cfg_pkg::OFS_CMD_STAT: begin
				rd_img[8:0]                        = cmd_q;
				rd_img[pci_cfg_pkg::ST_SPE_BIT]    = spe_q;
				rd_img[pci_cfg_pkg::ST_SES_BIT]    = ses_q;
				rd_img[pci_cfg_pkg::ST_SMA_BIT]    = sma_q;
				rd_img[pci_cfg_pkg::ST_STA_BIT]    = sta_q;
				rd_img[pci_cfg_pkg::ST_SDST_LSB +: 2] = pci_cfg_pkg::ST_SDST_VAL;
				rd_img[pci_cfg_pkg::ST_SDPR_BIT]   = sdpr_q;
				rd_img[pci_cfg_pkg::ST_SFBB_BIT]   = 1'b1;
				rd_img[pci_cfg_pkg::ST_NC_BIT]     = nc_enable;
			end
			pci_cfg_pkg::OFS_CLASS:    rd_img = {pci_cfg_pkg::CLASS_CODE, pci_cfg_pkg::REV_STEP};
			pci_cfg_pkg::OFS_LATENCY:  rd_img = {16'h0000, lat_q, cls_q}; // [RULE_13]
			pci_cfg_pkg::OFS_IO_BASE:  rd_img = {iob_q, 7'h01};
			pci_cfg_pkg::OFS_MEM_BASE: rd_img = {mb_q, 7'h00};
			pci_cfg_pkg::OFS_SUBSYS:
				rd_img = {ee_q[pci_cfg_pkg::EE_SUB_DEV], ee_q[pci_cfg_pkg::EE_SUB_VEN]};
			pci_cfg_pkg::OFS_ROM_BASE: rd_img = {rom_q, 13'h0000, rom_en_q}; // [RULE_10]
			pci_cfg_pkg::OFS_CAP_PTR:  rd_img = {24'h000000, pci_cfg_pkg::CAP_PTR};
			pci_cfg_pkg::OFS_INTR:
				rd_img = {ee_q[pci_cfg_pkg::EE_GNT_LAT], pci_cfg_pkg::INTR_PIN, iline_q}; // [RULE_13]
			pci_cfg_pkg::OFS_SCRATCH:  rd_img = {16'h0000, drv_q, 8'h00}; // [RULE_08]
			pci_cfg_pkg::OFS_SIGNATURE: rd_img = pci_cfg_pkg::SIGNATURE; // [RULE_09]
			pci_cfg_pkg::OFS_PM_CAP:
				rd_img = {pci_cfg_pkg::PM_CAPS, pci_cfg_pkg::PM_NEXT_LINK,
				          pci_cfg_pkg::PM_CAP_CODE}; // [RULE_11]
			pci_cfg_pkg::OFS_PM_CTRL:
				rd_img = {16'h0000, pme_st_q, 6'h00, pme_en_q, 6'h00, ps_q}; // [RULE_12]
			default: rd_img = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// Next state of writable fields and status flags
	// ------------------------------------------------------------
	always_comb begin
		logic [31:0] m;
		m        = 32'h0000_0000;
		cmd_d    = cmd_q;
		cls_d    = cls_q;
		lat_d    = lat_q;
		iob_d    = iob_q;
		mb_d     = mb_q;
		rom_d    = rom_q;
		rom_en_d = rom_en_q;
		iline_d  = iline_q;
		drv_d    = drv_q;
		ps_d     = ps_q;
		pme_en_d = pme_en_q;
		spe_d    = spe_q;
		ses_d    = ses_q;
		sma_d    = sma_q;
		sta_d    = sta_q;
		sdpr_d   = sdpr_q;
		pme_st_d = pme_st_q;
		if (wr_take) begin
			m = merge(rd_img, cfg_wdata, wmask); // [RULE_03]
			case (byte_ofs)
				pci_cfg_pkg::OFS_CMD_STAT: begin
					cmd_d  = (cmd_q & ~pci_cfg_pkg::CMD_WR_MASK) | (m[8:0] & pci_cfg_pkg::CMD_WR_MASK);
					spe_d  = spe_q && !w1c[pci_cfg_pkg::ST_SPE_BIT];
					ses_d  = ses_q && !w1c[pci_cfg_pkg::ST_SES_BIT];
					sma_d  = sma_q && !w1c[pci_cfg_pkg::ST_SMA_BIT];
					sta_d  = sta_q && !w1c[pci_cfg_pkg::ST_STA_BIT];
					sdpr_d = sdpr_q && !w1c[pci_cfg_pkg::ST_SDPR_BIT];
				end
				pci_cfg_pkg::OFS_LATENCY: begin
					cls_d = m[7:0];  // [RULE_13]
					lat_d = m[15:8]; // [RULE_13]
				end
				pci_cfg_pkg::OFS_IO_BASE:  iob_d = m[31:pci_cfg_pkg::IO_BASE_LSB];
				pci_cfg_pkg::OFS_MEM_BASE: mb_d  = m[31:pci_cfg_pkg::MEM_BASE_LSB];
				pci_cfg_pkg::OFS_ROM_BASE: begin
					rom_d    = m[31:pci_cfg_pkg::ROM_BASE_LSB]; // [RULE_10]
					rom_en_d = m[0];
				end
				pci_cfg_pkg::OFS_INTR:    iline_d = m[7:0];
				pci_cfg_pkg::OFS_SCRATCH: drv_d   = m[15:8]; // [RULE_08]
				pci_cfg_pkg::OFS_PM_CTRL: begin
					ps_d     = m[1:0];
					pme_en_d = m[pci_cfg_pkg::PMCS_PME_EN];
					pme_st_d = pme_st_q && !w1c[pci_cfg_pkg::PMCS_PME_ST];
				end
				default: m = 32'h0000_0000; // [RULE_15]
			endcase
		end
		// Events win over a clear in the same cycle
		if (parity_err_det) begin
			spe_d = 1'b1; // [RULE_14]
		end
		if (sys_err_sig) begin
			ses_d = 1'b1;
		end
		if (master_abort_rx) begin
			sma_d = 1'b1;
		end
		if (target_abort_rx) begin
			sta_d = 1'b1;
		end
		if (data_parity_err && cmd_q[pci_cfg_pkg::CMD_PERR_BIT]) begin
			sdpr_d = 1'b1;
		end
		if (pme_event) begin
			pme_st_d = 1'b1;
		end
		ack_d   = take;
		rdata_d = rd_take ? rd_img : rdata_q;
	end

	// ------------------------------------------------------------
	// Registers; only the hardware reset restores defaults
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_q    <= pci_cfg_pkg::CMD_RESET; // [RULE_01]
			cls_q    <= 8'h00;
			lat_q    <= 8'h00;
			iob_q    <= '0;
			mb_q     <= '0;
			rom_q    <= '0;
			rom_en_q <= 1'b0;
			iline_q  <= 8'h00;
			drv_q    <= 8'h00;
			ps_q     <= 2'h0;
			pme_en_q <= 1'b0;
			spe_q    <= 1'b0;
			ses_q    <= 1'b0;
			sma_q    <= 1'b0;
			sta_q    <= 1'b0;
			sdpr_q   <= 1'b0;
			pme_st_q <= 1'b0;
			ack_q    <= 1'b0;
			rdata_q  <= 32'h0000_0000;
		end else if (ce) begin
			// Software reset has no term here: contents survive it [RULE_02]
			cmd_q    <= cmd_d;
			cls_q    <= cls_d;
			lat_q    <= lat_d;
			iob_q    <= iob_d;
			mb_q     <= mb_d;
			rom_q    <= rom_d;
			rom_en_q <= rom_en_d;
			iline_q  <= iline_d;
			drv_q    <= drv_d;
			ps_q     <= ps_d;
			pme_en_q <= pme_en_d;
			spe_q    <= spe_d;
			ses_q    <= ses_d;
			sma_q    <= sma_d;
			sta_q    <= sta_d;
			sdpr_q   <= sdpr_d;
			pme_st_q <= pme_st_d;
			ack_q    <= ack_d;
			rdata_q  <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs and address window decode
	// ------------------------------------------------------------
	assign cfg_ack         = ack_q;
	assign cfg_rdata       = rdata_q;
	assign io_space_en     = cmd_q[pci_cfg_pkg::CMD_IO_BIT];
	assign mem_space_en    = cmd_q[pci_cfg_pkg::CMD_MEM_BIT];
	assign bus_master_en   = cmd_q[pci_cfg_pkg::CMD_MASTER_BIT];
	assign parity_resp_en  = cmd_q[pci_cfg_pkg::CMD_PERR_BIT];
	assign serr_en         = cmd_q[pci_cfg_pkg::CMD_SERR_BIT];
	assign cache_line_size = cls_q;
	assign latency_timer   = lat_q;
	assign interrupt_line  = iline_q;
	assign power_state     = ps_q;
	assign pme_en          = pme_en_q;

	assign csr_io_hit  = io_space_en &&
	                     (bus_addr[31:pci_cfg_pkg::IO_BASE_LSB] == iob_q);  // [RULE_04]
	assign csr_mem_hit = mem_space_en &&
	                     (bus_addr[31:pci_cfg_pkg::MEM_BASE_LSB] == mb_q);  // [RULE_04]
	assign rom_hit     = mem_space_en && rom_en_q &&
	                     (bus_addr[31:pci_cfg_pkg::ROM_BASE_LSB] == rom_q); // [RULE_10]

	assign mii_reg_valid = (mii_reg_addr <= pci_cfg_pkg::MII_STD_LAST) ||
	                       ((mii_reg_addr >= pci_cfg_pkg::MII_VND_FIRST) &&
	                        (mii_reg_addr <= pci_cfg_pkg::MII_VND_LAST)); // [RULE_05]

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_read(logic [7:0] ofs);
		rd_take && byte_ofs == ofs;
	endsequence

	sequence s_scratch_lane1_write;
		wr_take && byte_ofs == pci_cfg_pkg::OFS_SCRATCH && !cfg_be_n[1];
	endsequence

	AST_RESET_DEFAULTS: assert property (disable iff (1'b0) // [RULE_01]
		rst |=> cmd_q == pci_cfg_pkg::CMD_RESET && !spe_q && drv_q == 8'h00 && !rom_en_q)
		else $error("defaults not restored by hardware reset");

	AST_SWRST_KEEPS: assert property ( // [RULE_02]
		sw_rst && !take && !parity_err_det |=> $stable(cmd_q) && $stable(drv_q) && $stable(lat_q))
		else $error("software reset disturbed configuration contents");

	AST_LANE_STORE: assert property ( // [RULE_03]
		s_scratch_lane1_write |=> drv_q == $past(cfg_wdata[15:8]))
		else $error("enabled byte lane not stored");

	AST_LANE_SKIP: assert property ( // [RULE_03]
		wr_take && byte_ofs == pci_cfg_pkg::OFS_LATENCY && cfg_be_n[1] |=> $stable(lat_q))
		else $error("disabled byte lane was written");

	AST_IO_WINDOW: assert property ( // [RULE_04]
		csr_io_hit |-> io_space_en && bus_addr[31:pci_cfg_pkg::IO_BASE_LSB] == iob_q)
		else $error("control window hit outside its base");

	AST_MII_COUNT: assert property ( // [RULE_05]
		mii_reg_addr == 5'h07 || mii_reg_addr == 5'h14 |-> !mii_reg_valid)
		else $error("transceiver register map too wide");

	AST_ID_WORD: assert property ( // [RULE_06]
		s_read(pci_cfg_pkg::OFS_ID) |=> cfg_ack &&
		cfg_rdata == {ee_q[pci_cfg_pkg::EE_DEVICE], ee_q[pci_cfg_pkg::EE_VENDOR]})
		else $error("identity word mismatch");

	AST_SCRATCH_RSVD: assert property ( // [RULE_08]
		s_read(pci_cfg_pkg::OFS_SCRATCH) |=> cfg_ack && cfg_rdata[31:16] == 16'h0000 &&
		cfg_rdata[7:0] == 8'h00 && cfg_rdata[15:8] == drv_q)
		else $error("scratch register read wrong");

	AST_SIGNATURE: assert property ( // [RULE_09]
		s_read(pci_cfg_pkg::OFS_SIGNATURE) |=> cfg_rdata == pci_cfg_pkg::SIGNATURE)
		else $error("signature not fixed");

	AST_ROM_WINDOW: assert property ( // [RULE_10]
		rom_hit |-> rom_en_q && bus_addr[31:pci_cfg_pkg::ROM_BASE_LSB] == rom_q)
		else $error("boot ROM window decode wrong");

	AST_PM_CAP: assert property ( // [RULE_11]
		s_read(pci_cfg_pkg::OFS_PM_CAP) |=> cfg_rdata[7:0] == pci_cfg_pkg::PM_CAP_CODE &&
		cfg_rdata[31:16] == pci_cfg_pkg::PM_CAPS)
		else $error("capability word wrong");

	AST_PM_CTRL: assert property ( // [RULE_12]
		s_read(pci_cfg_pkg::OFS_PM_CTRL) |=> cfg_rdata[31:16] == 16'h0000 &&
		cfg_rdata[1:0] == ps_q)
		else $error("power control word wrong");

	AST_LATENCY: assert property ( // [RULE_13]
		s_read(pci_cfg_pkg::OFS_LATENCY) |=> cfg_rdata == {16'h0000, latency_timer, cache_line_size})
		else $error("latency word wrong");

	AST_PARITY_SET: assert property ( // [RULE_14]
		parity_err_det && ce |=> spe_q)
		else $error("parity error flag not set");

	AST_RSVD_ZERO: assert property ( // [RULE_15]
		s_read(pci_cfg_pkg::OFS_RSVD_LOW) |=> cfg_rdata == 32'h0000_0000)
		else $error("reserved offset read nonzero");

	AST_ACK_PULSE: assert property ( // [RULE_16]
		take |=> cfg_ack)
		else $error("configuration access not acknowledged");

endmodule : pci_config_register_bank

`default_nettype wire

// ===== eeprom_model.sv
`timescale 1ns/100ps
`default_nettype none

module eeprom_model (
	input  wire logic       clk,
	input  wire logic       ee_req,
	input  wire logic [2:0] ee_word,
	output logic [15:0]     ee_rdata,
	output logic            ee_rvalid
);
	int          wait_q;
	logic [15:0] last_q;
	initial begin
		wait_q = -1;
		last_q = 16'h0000;
	end
	// Odd words answer slowly; idle data shows the inverse of the last word
	always @(posedge clk) begin
		ee_rvalid <= 1'b0;
		ee_rdata <= ~last_q;
		if (ee_req) begin
			wait_q <= ee_word[0] ? 5 : 0;
		end else if (wait_q > 0) begin
			wait_q <= wait_q - 1;
		end else if (wait_q == 0) begin
			ee_rvalid <= 1'b1;
			ee_rdata <= 16'ha5a0 + {13'h0000, ee_word};
			last_q <= 16'ha5a0 + {13'h0000, ee_word};
			wait_q <= -1;
		end
	end
endmodule : eeprom_model

`default_nettype wire

// ===== pci_config_register_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none

module pci_config_register_bank_tb;
	logic        clk = 1'b0, rst = 1'b1, sw_rst = 1'b0, sel = 1'b0, ev = 1'b0, pme = 1'b0;
	logic [3:0]  cmd = 4'h0, be_n = 4'hf;
	logic [5:0]  dw = 6'h00;
	logic [31:0] wd = 32'h0, rd;
	logic [4:0]  mii = 5'h00;
	logic [31:0] ba = 32'h0;
	logic        io_hit, mem_hit, rom_hit;
	logic        ack, ee_req, ee_rvalid, done, mii_ok;
	logic [2:0]  ee_word;
	logic [15:0] ee_rdata;
	int          err_count = 0, n_checks = 0;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end

	always #12.5 clk = ~clk;

	pci_config_register_bank u_dut (.clk(clk), .rst(rst), .ce(1'b1), .sw_rst(sw_rst),
		.cfg_sel(sel), .cfg_cmd(cmd), .cfg_dword(dw), .cfg_be_n(be_n), .cfg_wdata(wd),
		.cfg_ack(ack), .cfg_rdata(rd), .ee_req(ee_req), .ee_word(ee_word),
		.ee_rdata(ee_rdata), .ee_rvalid(ee_rvalid), .recall_done(done),
		.parity_err_det(ev), .sys_err_sig(ev), .master_abort_rx(ev), .target_abort_rx(ev),
		.data_parity_err(1'b0), .nc_enable(1'b1), .pme_event(pme), .bus_addr(ba),
		.csr_io_hit(io_hit), .csr_mem_hit(mem_hit), .rom_hit(rom_hit), .mii_reg_addr(mii),
		.mii_reg_valid(mii_ok), .io_space_en(), .mem_space_en(), .bus_master_en(),
		.parity_resp_en(), .serr_en(), .cache_line_size(), .latency_timer(),
		.interrupt_line(), .power_state(), .pme_en());

	eeprom_model u_ee (.clk(clk), .ee_req(ee_req), .ee_word(ee_word),
		.ee_rdata(ee_rdata), .ee_rvalid(ee_rvalid));

	// ----------------------------------------------------------------
	// Shared access tasks
	// ----------------------------------------------------------------
	task automatic acc(input logic [3:0] c, input logic [7:0] ofs, input logic [3:0] b,
			input logic [31:0] d);
		@(posedge clk);
		sel <= 1'b1;
		cmd <= c;
		dw <= ofs[7:2];
		be_n <= b;
		wd <= d;
		@(posedge clk);
		sel <= 1'b0;
		#1;
		`CHK(ack, 1'b1)
	endtask : acc

	task automatic rchk(input logic [7:0] ofs, input logic [31:0] exp);
		acc(pci_cfg_pkg::CMD_CFG_READ, ofs, 4'h0, 32'h0);
		`CHK(rd, exp)
	endtask : rchk

	task automatic hw_reset();
		@(posedge clk);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 200 && done !== 1'b1; i++) @(posedge clk);
		`CHK(done, 1'b1)
	endtask : hw_reset

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_defaults();
		rchk(8'h04, 32'h0290_0107);
		rchk(8'h00, 32'ha5a1_a5a0);
		rchk(8'h2c, 32'ha5a3_a5a2);
		rchk(8'h3c, 32'ha5a4_0100);
		rchk(8'h0c, 32'h0000_0000);
		rchk(8'h18, 32'h0000_0000);
		rchk(8'hc0, 32'h0002_0001);
	endtask : t_defaults

	task automatic t_lanes();
		acc(pci_cfg_pkg::CMD_CFG_WRITE, 8'h40, 4'hd, 32'hffff_ffff);
		rchk(8'h40, 32'h0000_ff00);
		acc(pci_cfg_pkg::CMD_CFG_WRITE, 8'h40, 4'hb, 32'h0000_0000);
		rchk(8'h40, 32'h0000_ff00);
		acc(pci_cfg_pkg::CMD_CFG_WRITE, 8'h0c, 4'hc, 32'hffff_1234);
		rchk(8'h0c, 32'h0000_1234);
		@(posedge clk);
		sw_rst <= 1'b1;
		@(posedge clk);
		sw_rst <= 1'b0;
		rchk(8'h40, 32'h0000_ff00);
	endtask : t_lanes

	task automatic t_fixed();
		acc(pci_cfg_pkg::CMD_CFG_WRITE, 8'h80, 4'h0, 32'h0);
		rchk(8'h80, pci_cfg_pkg::SIGNATURE);
		acc(pci_cfg_pkg::CMD_CFG_WRITE, 8'h00, 4'h0, 32'h0);
		rchk(8'h00, 32'ha5a1_a5a0);
		acc(pci_cfg_pkg::CMD_CFG_WRITE, 8'h30, 4'h0, 32'hffff_ffff);
		rchk(8'h30, 32'hffff_c001);
		acc(pci_cfg_pkg::CMD_CFG_WRITE, 8'hc4, 4'h0, 32'hffff_ffff);
		rchk(8'hc4, 32'h0000_0103);
	endtask : t_fixed

	task automatic t_win();
		acc(pci_cfg_pkg::CMD_CFG_WRITE, 8'h10, 4'h0, 32'h0000_1280);
		acc(pci_cfg_pkg::CMD_CFG_WRITE, 8'h14, 4'h0, 32'h4000_0000);
		@(posedge clk);
		ba <= 32'h0000_12a4;
		#1;
		`CHK({io_hit, mem_hit, rom_hit}, 3'b100)
		@(posedge clk);
		ba <= 32'h4000_0010;
		#1;
		`CHK({io_hit, mem_hit, rom_hit}, 3'b010)
		@(posedge clk);
		ba <= 32'hffff_c123;
		#1;
		`CHK({io_hit, mem_hit, rom_hit}, 3'b001)
	endtask : t_win

	task automatic t_events();
		@(posedge clk);
		ev <= 1'b1;
		pme <= 1'b1;
		@(posedge clk);
		ev <= 1'b0;
		pme <= 1'b0;
		rchk(8'h04, 32'hf290_0107);
		rchk(8'hc4, 32'h0000_8103);
		acc(pci_cfg_pkg::CMD_CFG_WRITE, 8'h04, 4'h3, 32'hffff_0000);
		rchk(8'h04, 32'h0290_0107);
	endtask : t_events

	task automatic t_mii();
		for (int a = 0; a < 32; a++) begin
			@(posedge clk);
			mii <= a[4:0];
			#1;
			`CHK(mii_ok, (a <= 6) || (a >= 16 && a <= 19))
		end
	endtask : t_mii

	task automatic close_out();
		$display("Checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	initial begin
		hw_reset();
		t_defaults();
		t_lanes();
		t_fixed();
		t_win();
		t_events();
		t_mii();
		hw_reset();
		rchk(8'h40, 32'h0000_0000);
		rchk(8'h30, 32'h0000_0000);
		close_out();
	end

	initial begin
		#100000;
		err_count++;
		close_out();
	end
endmodule : pci_config_register_bank_tb

`default_nettype wire
